// ==== hdl/indirect_addr_unit.sv ====
// Indirect data-memory addressing unit with APB register access
//
// Implementation choice: register access over APB.
`default_nettype none
module indirect_addr_unit
  import ptr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  // ***********************************
  // Decode
  // ***********************************
  function automatic logic [8:0] regIndex(input logic [APB_AW-1:0] a);
    regIndex = 9'(a >> WORD_SHIFT);
  endfunction : regIndex

  function automatic logic inGpr(input logic [8:0] a);
    inGpr = (a >= GPR_BASE) && (a <= GPR_LAST);
  endfunction : inGpr

  logic [8:0] ptrZero;
  logic [8:0] ptrOne;
  logic [7:0] working;
  logic [8:0] next_ptrZero;
  logic [8:0] next_ptrOne;
  logic [7:0] next_working;
  xfer_e state;
  xfer_e next_state;
  logic [31:0] regData;
  logic [31:0] next_regData;
  logic next_pslverr;
  logic [8:0] idx;
  logic isWin;
  logic winOne;
  logic [2:0] winMode;
  addr_req_s req;
  addr_res_s res;
  logic [8:0] memAddr;
  logic memWe;
  logic [7:0] memRdata;
  logic [7:0] memWdata;
  logic [MEM_AW-1:0] memIdx;
  logic setup;

  assign idx = regIndex(paddr);
  assign setup = psel && !penable;
  assign isWin = idx <= WIN_P1_OFFSET;
  assign winOne = isWin && (idx >= WIN_P1_PLAIN);
  assign winMode = 3'(winOne ? 9'(idx - WIN_P1_PLAIN) : idx);
  assign memWdata = pwdata[7:0];

  always_comb begin
    req.ptr = winOne ? ptrOne : ptrZero;
    req.work = working;
    req.mode = winMode;
  end

  ptr_addr_gen u_gen (
    .req(req),
    .res(res)
  );

  // ***********************************
  // Memory port
  // ***********************************
  always_comb begin
    memAddr = isWin ? res.addr : idx;
    memIdx = memAddr[MEM_AW-1:0] ^ GPR_BASE[MEM_AW-1:0];
    memWe = setup && pwrite && (isWin || inGpr(idx)) && inGpr(memAddr);
  end

  gpr_mem u_mem (
    .ref_clk(ref_clk),
    .we(memWe),
    .addr(memIdx),
    .wdata(memWdata),
    .rdata(memRdata)
  );

  // ***********************************
  // Transfer sequencing
  // ***********************************
  always_comb begin
    next_state = state;
    next_ptrZero = ptrZero;
    next_ptrOne = ptrOne;
    next_working = working;
    next_pslverr = 1'b0;
    case (state)
      IDLE: begin
        if (setup) begin
          next_state = MEM_WAIT;
          if (isWin) begin
            if (winOne) begin
              next_ptrOne = res.ptrNext;
            end else begin
              next_ptrZero = res.ptrNext;
            end
            next_pslverr = !inGpr(memAddr);
          end else if (pwrite) begin
            case (idx)
              REG_P0_HIGH: next_ptrZero[8] = pwdata[0];
              REG_P0_LOW: next_ptrZero[7:0] = pwdata[7:0];
              REG_P1_HIGH: next_ptrOne[8] = pwdata[0];
              REG_P1_LOW: next_ptrOne[7:0] = pwdata[7:0];
              REG_WORKING: next_working = pwdata[7:0];
              default: next_pslverr = !inGpr(idx);
            endcase
          end else begin
            case (idx)
              REG_P0_HIGH, REG_P0_LOW, REG_P1_HIGH, REG_P1_LOW, REG_WORKING: begin
                next_pslverr = 1'b0;
              end
              default: next_pslverr = !inGpr(idx);
            endcase
          end
        end
      end
      MEM_WAIT: begin
        next_pslverr = pslverr;
        if (psel && penable) begin
          next_state = IDLE;
        end
      end
      default: begin
        next_state = IDLE;
      end
    endcase
  end

  // Read data captured at setup, memory data merged in access phase
  logic [31:0] regRd;
  logic useMem;
  logic next_useMem;

  always_comb begin
    regRd = '0;
    case (idx)
      REG_P0_HIGH: regRd = {31'h0000_0000, ptrZero[8]};
      REG_P0_LOW: regRd = {24'h00_0000, ptrZero[7:0]};
      REG_P1_HIGH: regRd = {31'h0000_0000, ptrOne[8]};
      REG_P1_LOW: regRd = {24'h00_0000, ptrOne[7:0]};
      REG_WORKING: regRd = {24'h00_0000, working};
      default: regRd = '0;
    endcase
    next_useMem = useMem;
    next_regData = regData;
    if (state == IDLE && setup) begin
      next_useMem = isWin || inGpr(idx);
      next_regData = regRd;
    end
  end

  // Low bytes and working register keep their value across reset
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state <= IDLE;
      ptrZero[8] <= 1'b0;
      ptrOne[8] <= 1'b0;
      regData <= '0;
      pslverr <= 1'b0;
      useMem <= 1'b0;
    end else begin
      state <= next_state;
      ptrZero <= next_ptrZero;
      ptrOne <= next_ptrOne;
      working <= next_working;
      regData <= next_regData;
      pslverr <= next_pslverr;
      useMem <= next_useMem;
    end
  end

  logic [31:0] rdOut;
  assign rdOut = useMem ? {24'h00_0000, memRdata} : regData;
  assign prdata = rdOut;
  assign pready = (state == MEM_WAIT);

  // ***********************************
  // Checks
  // ***********************************
  a_plain_keeps_ptr: assert property (@(posedge ref_clk) disable iff (srst)
    (state == IDLE && setup && idx == WIN_P0_PLAIN) |=> ptrZero == $past(ptrZero))
    else $error("plain window changed pointer");
  a_postinc_step: assert property (@(posedge ref_clk) disable iff (srst)
    (state == IDLE && setup && idx == WIN_P0_POSTINC) |=> ptrZero == 9'($past(ptrZero) + 1))
    else $error("post-increment wrong");
  a_postdec_step: assert property (@(posedge ref_clk) disable iff (srst)
    (state == IDLE && setup && idx == WIN_P0_POSTDEC) |=> ptrZero == 9'($past(ptrZero) - 1))
    else $error("post-decrement wrong");
  a_preinc_addr: assert property (@(posedge ref_clk) disable iff (srst)
    (state == IDLE && setup && idx == WIN_P0_PREINC) |-> memAddr == 9'(ptrZero + 1))
    else $error("pre-increment address wrong");
  a_offset_addr: assert property (@(posedge ref_clk) disable iff (srst)
    (state == IDLE && setup && idx == WIN_P0_OFFSET)
      |-> memAddr == 9'(ptrZero + working) ##1 $stable(working))
    else $error("offset address wrong");
  a_one_keeps_zero: assert property (@(posedge ref_clk) disable iff (srst)
    (state == IDLE && setup && winOne) |=> ptrZero == $past(ptrZero))
    else $error("pointer one window touched pointer zero");
  a_high_write: assert property (@(posedge ref_clk) disable iff (srst)
    (state == IDLE && setup && pwrite && idx == REG_P0_HIGH) |=> ptrZero[8] == $past(pwdata[0]))
    else $error("high bit write lost");
  a_low_write: assert property (@(posedge ref_clk) disable iff (srst)
    (state == IDLE && setup && pwrite && idx == REG_P1_LOW) |=> ptrOne[7:0] == $past(pwdata[7:0]))
    else $error("low byte write lost");
  a_answer_time: assert property (@(posedge ref_clk) disable iff (srst)
    (state == IDLE && setup) |=> pready)
    else $error("no answer in one cycle");

  // ***********************************
  // Pointer zero windows
  // ***********************************
  a_plain_addr: assert property (@(posedge ref_clk) disable iff (srst)
    (state == IDLE && setup && idx == WIN_P0_PLAIN) |-> memAddr == ptrZero)
    else $error("plain window address wrong");
  a_postinc_addr: assert property (@(posedge ref_clk) disable iff (srst)
    (state == IDLE && setup && idx == WIN_P0_POSTINC) |-> memAddr == ptrZero)
    else $error("post-increment address wrong");
  a_postdec_addr: assert property (@(posedge ref_clk) disable iff (srst)
    (state == IDLE && setup && idx == WIN_P0_POSTDEC) |-> memAddr == ptrZero)
    else $error("post-decrement address wrong");
  a_preinc_step: assert property (@(posedge ref_clk) disable iff (srst)
    (state == IDLE && setup && idx == WIN_P0_PREINC)
      |=> ptrZero == 9'($past(ptrZero) + PTR_STEP))
    else $error("pre-increment step wrong");
  a_offset_keeps: assert property (@(posedge ref_clk) disable iff (srst)
    (state == IDLE && setup && idx == WIN_P0_OFFSET) |=> ptrZero == $past(ptrZero))
    else $error("offset window changed pointer");
  a_postinc_wrap: assert property (@(posedge ref_clk) disable iff (srst)
    (state == IDLE && setup && idx == WIN_P0_POSTINC && &ptrZero)
      |=> ptrZero == '0)
    else $error("post-increment did not wrap");

  // ***********************************
  // Pointer one windows
  // ***********************************
  a_one_plain_keeps: assert property (@(posedge ref_clk) disable iff (srst)
    (state == IDLE && setup && idx == WIN_P1_PLAIN) |=> ptrOne == $past(ptrOne))
    else $error("pointer one plain window changed pointer");
  a_one_plain_addr: assert property (@(posedge ref_clk) disable iff (srst)
    (state == IDLE && setup && idx == WIN_P1_PLAIN) |-> memAddr == ptrOne)
    else $error("pointer one plain address wrong");
  a_one_postinc: assert property (@(posedge ref_clk) disable iff (srst)
    (state == IDLE && setup && idx == 9'(WIN_P1_PLAIN + MODE_POSTINC))
      |=> ptrOne == 9'($past(ptrOne) + PTR_STEP))
    else $error("pointer one post-increment wrong");
  a_one_postdec: assert property (@(posedge ref_clk) disable iff (srst)
    (state == IDLE && setup && idx == 9'(WIN_P1_PLAIN + MODE_POSTDEC))
      |=> ptrOne == 9'($past(ptrOne) - PTR_STEP))
    else $error("pointer one post-decrement wrong");
  a_one_preinc_step: assert property (@(posedge ref_clk) disable iff (srst)
    (state == IDLE && setup && idx == 9'(WIN_P1_PLAIN + MODE_PREINC))
      |=> ptrOne == 9'($past(ptrOne) + PTR_STEP))
    else $error("pointer one pre-increment step wrong");
  a_one_preinc_addr: assert property (@(posedge ref_clk) disable iff (srst)
    (state == IDLE && setup && idx == 9'(WIN_P1_PLAIN + MODE_PREINC))
      |-> memAddr == 9'(ptrOne + PTR_STEP))
    else $error("pointer one pre-increment address wrong");
  a_one_offset_addr: assert property (@(posedge ref_clk) disable iff (srst)
    (state == IDLE && setup && idx == WIN_P1_OFFSET)
      |-> memAddr == 9'(ptrOne + working))
    else $error("pointer one offset address wrong");
  a_zero_keeps_one: assert property (@(posedge ref_clk) disable iff (srst)
    (state == IDLE && setup && isWin && !winOne) |=> ptrOne == $past(ptrOne))
    else $error("pointer zero window touched pointer one");
  a_postdec_wrap: assert property (@(posedge ref_clk) disable iff (srst)
    (state == IDLE && setup && idx == 9'(WIN_P1_PLAIN + MODE_POSTDEC) && ptrOne == '0)
      |=> &ptrOne)
    else $error("post-decrement did not wrap");

  // ***********************************
  // Pointer registers, reset and banks
  // ***********************************
  a_low0_write: assert property (@(posedge ref_clk) disable iff (srst)
    (state == IDLE && setup && pwrite && idx == REG_P0_LOW)
      |=> ptrZero[7:0] == $past(pwdata[7:0]))
    else $error("pointer zero low byte write lost");
  a_high1_write: assert property (@(posedge ref_clk) disable iff (srst)
    (state == IDLE && setup && pwrite && idx == REG_P1_HIGH)
      |=> ptrOne[8] == $past(pwdata[0]))
    else $error("pointer one high bit write lost");
  a_high0_read: assert property (@(posedge ref_clk) disable iff (srst)
    (state == IDLE && setup && !pwrite && idx == REG_P0_HIGH)
      |=> prdata == {31'h0000_0000, $past(ptrZero[8])})
    else $error("pointer zero high bit read wrong");
  a_low1_read: assert property (@(posedge ref_clk) disable iff (srst)
    (state == IDLE && setup && !pwrite && idx == REG_P1_LOW)
      |=> prdata[7:0] == $past(ptrOne[7:0]))
    else $error("pointer one low byte read wrong");
  a_low_kept: assert property (@(posedge ref_clk)
    (srst && !$past(srst))
      |=> ptrZero[7:0] == $past(ptrZero[7:0]) && ptrOne[7:0] == $past(ptrOne[7:0]))
    else $error("pointer low byte lost at reset");
  a_bank_error: assert property (@(posedge ref_clk) disable iff (srst)
    (state == IDLE && setup && isWin)
      |=> pslverr == ($past(memAddr) < GPR_BASE || $past(memAddr) > GPR_LAST))
    else $error("window bank error flag wrong");
endmodule : indirect_addr_unit
`default_nettype wire

// ==== hdl/ptr_pkg.sv ====
// Package: offsets, field layouts and carriers for the indirect addressing unit
`default_nettype none
package ptr_pkg;
  localparam int APB_AW = 12;
  localparam int MEM_AW = 8;
  localparam logic [8:0] WIN_P0_PLAIN = 9'h0_000;
  localparam logic [8:0] WIN_P0_POSTINC = 9'h0_001;
  localparam logic [8:0] WIN_P0_POSTDEC = 9'h0_002;
  localparam logic [8:0] WIN_P0_PREINC = 9'h0_003;
  localparam logic [8:0] WIN_P0_OFFSET = 9'h0_004;
  localparam logic [8:0] WIN_P1_PLAIN = 9'h0_005;
  localparam logic [8:0] WIN_P1_OFFSET = 9'h0_009;
  localparam logic [8:0] REG_P0_HIGH = 9'h0_00F;
  localparam logic [8:0] REG_P0_LOW = 9'h0_010;
  localparam logic [8:0] REG_P1_HIGH = 9'h0_011;
  localparam logic [8:0] REG_P1_LOW = 9'h0_012;
  localparam logic [8:0] REG_WORKING = 9'h0_029;
  localparam logic [8:0] GPR_BASE = 9'h0_080;
  localparam logic [8:0] GPR_LAST = 9'h0_17F;
  localparam logic [8:0] PTR_STEP = 9'h0_001;
  localparam logic [1:0] WORD_SHIFT = 2'h2;
  localparam logic [2:0] MODE_PLAIN = 3'h0;
  localparam logic [2:0] MODE_POSTINC = 3'h1;
  localparam logic [2:0] MODE_POSTDEC = 3'h2;
  localparam logic [2:0] MODE_PREINC = 3'h3;
  localparam logic [2:0] MODE_OFFSET = 3'h4;
  localparam int NUM_WIN = 5;

  typedef struct packed {
    logic [8:0] ptr;
    logic [7:0] work;
    logic [2:0] mode;
  } addr_req_s;

  typedef struct packed {
    logic [8:0] addr;
    logic [8:0] ptrNext;
  } addr_res_s;

  typedef enum logic [1:0] {
    IDLE,
    MEM_WAIT,
    DONE
  } xfer_e;
endpackage : ptr_pkg
`default_nettype wire

// ==== hdl/gpr_mem.sv ====
// General purpose data memory, two banks of 128 bytes, registered read
`default_nettype none
module gpr_mem
  import ptr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic we,
  input wire logic [MEM_AW-1:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  // ***********************************
  // Storage
  // ***********************************
  logic [7:0] mem [0:(1<<MEM_AW)-1];
  logic [7:0] next_rdata;

  always_comb begin
    next_rdata = mem[addr];
  end

  always_ff @(posedge ref_clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= next_rdata;
  end
endmodule : gpr_mem
`default_nettype wire

// ==== hdl/ptr_addr_gen.sv ====
// Window address and pointer update arithmetic
`default_nettype none
module ptr_addr_gen
  import ptr_pkg::*;
(
  input wire addr_req_s req,
  output addr_res_s res
);
  function automatic logic [8:0] step(input logic [8:0] p, input logic up);
    step = up ? 9'(p + PTR_STEP) : 9'(p - PTR_STEP);
  endfunction : step

  always_comb begin
    res.addr = req.ptr;
    res.ptrNext = req.ptr;
    case (req.mode)
      MODE_PLAIN: begin
        res.ptrNext = req.ptr;
      end
      MODE_POSTINC: begin
        res.ptrNext = step(req.ptr, 1'b1);
      end
      MODE_POSTDEC: begin
        res.ptrNext = step(req.ptr, 1'b0);
      end
      MODE_PREINC: begin
        res.ptrNext = step(req.ptr, 1'b1);
        res.addr = res.ptrNext;
      end
      MODE_OFFSET: begin
        res.addr = 9'(req.ptr + {1'b0, req.work});
      end
      default: begin
        res.addr = req.ptr;
      end
    endcase
  end
endmodule : ptr_addr_gen
`default_nettype wire

// ==== dv/apb_master_model.sv ====
// APB master model standing in for the core's register-file access
`default_nettype none
module apb_master_model
  import ptr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [APB_AW-1:0] paddr,
  output logic [31:0] pwdata
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
  end

  // One transfer; request held until pready seen at a rising edge, or dropped after 16 edges without it
  task automatic xfer(input logic wr, input logic [8:0] idx, input logic [7:0] wd,
      output logic [7:0] rd, output logic err, output logic ok);
    int n;
    ok = 1'b0;
    rd = 8'h00;
    err = 1'b0;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {1'b0, idx, 2'b00};
    pwdata <= {24'h00_0000, wd};
    @(posedge ref_clk);
    penable <= 1'b1;
    for (n = 0; n < 16 && !ok; n++) begin
      @(posedge ref_clk);
      if (pready === 1'b1) begin
        ok = 1'b1;
        rd = prdata[7:0];
        err = pslverr;
      end
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : apb_master_model
`default_nettype wire

// ==== dv/testbench.sv ====
// Self-checking bench for the indirect addressing unit
`default_nettype none
module testbench
  import ptr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic refClk, srst, psel, penable, pwrite, pready, pslverr;
  logic [APB_AW-1:0] paddr;
  logic [31:0] pwdata, prdata;
  int errorCnt = 0;
  int checked = 0;

  indirect_addr_unit dut_u (.ref_clk(refClk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  apb_master_model master_u (.ref_clk(refClk), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata));

  initial begin
    refClk = 1'b0;
    forever #12.5 refClk = ~refClk;
  end

  // ********************************
  // Checking tasks
  // ********************************
  task automatic conclude();
    $display("Mismatches %0d, comparisons %0d", errorCnt, checked);
    if (errorCnt == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : conclude

  task automatic cmp_data(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      errorCnt++;
      $display("unexpected data at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_data

  task automatic cmp_err(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      errorCnt++;
      $display("unexpected slave error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_err

  task automatic acc(input logic wr, input logic [8:0] idx, input logic [7:0] wd,
      output logic [7:0] rd, output logic err);
    logic ok;
    master_u.xfer(wr, idx, wd, rd, err, ok);
    if (!ok) begin
      errorCnt++;
      $display("unexpected hang at %0t: got %h expected %h", $time, 1'b0, 1'b1);
      conclude();
    end
  endtask : acc

  task automatic set_ptr(input logic p, input logic [8:0] v);
    logic [7:0] rd;
    logic e;
    acc(1'b1, p ? REG_P1_HIGH : REG_P0_HIGH, {7'h00, v[8]}, rd, e);
    acc(1'b1, p ? REG_P1_LOW : REG_P0_LOW, v[7:0], rd, e);
  endtask : set_ptr

  task automatic get_ptr(input logic p, input logic [8:0] exp);
    logic [7:0] rd;
    logic e;
    acc(1'b0, p ? REG_P1_HIGH : REG_P0_HIGH, 8'h00, rd, e);
    cmp_data(rd, {7'h00, exp[8]});
    acc(1'b0, p ? REG_P1_LOW : REG_P0_LOW, 8'h00, rd, e);
    cmp_data(rd, exp[7:0]);
  endtask : get_ptr

  // ********************************
  // Window scenario: write, then read back
  // ********************************
  task automatic check_window(input logic p, input logic [2:0] m, input logic [8:0] base,
      input logic [7:0] w);
    logic [8:0] a, n, win;
    logic [7:0] rd, d;
    logic e, inRange;
    win = (p ? WIN_P1_PLAIN : WIN_P0_PLAIN) + {6'h00, m};
    case (m)
      MODE_POSTINC: begin a = base; n = base + PTR_STEP; end
      MODE_POSTDEC: begin a = base; n = base - PTR_STEP; end
      MODE_PREINC: begin n = base + PTR_STEP; a = n; end
      MODE_OFFSET: begin a = base + {1'b0, w}; n = base; end
      default: begin a = base; n = base; end
    endcase
    inRange = (a >= GPR_BASE) && (a <= GPR_LAST);
    d = a[7:0] ^ w ^ {p, 4'h0, m};
    acc(1'b1, REG_WORKING, w, rd, e);
    set_ptr(p, base);
    acc(1'b1, win, d, rd, e);
    cmp_err(e, !inRange);
    set_ptr(p, base);
    acc(1'b0, win, 8'h00, rd, e);
    if (inRange) cmp_data(rd, d);
    get_ptr(p, n);
    acc(1'b0, REG_WORKING, 8'h00, rd, e);
    cmp_data(rd, w);
    if (inRange) begin
      acc(1'b0, a, 8'h00, rd, e);
      cmp_data(rd, d);
    end
  endtask : check_window

  initial begin
    logic [7:0] rd;
    logic e;
    srst = 1'b1;
    repeat (6) @(posedge refClk);
    srst <= 1'b0;
    acc(1'b0, REG_P0_HIGH, 8'h00, rd, e);
    cmp_data(rd, 8'h00);
    for (int p = 0; p < 2; p++) begin
      for (int m = 0; m < NUM_WIN; m++) begin
        check_window(p[0], m[2:0], 9'h0F0, 8'h10);
      end
    end
    check_window(1'b0, MODE_POSTINC, 9'h1FF, 8'h01);
    check_window(1'b1, MODE_POSTDEC, 9'h000, 8'h02);
    check_window(1'b0, MODE_PREINC, 9'h17E, 8'h03);
    check_window(1'b1, MODE_PREINC, 9'h17F, 8'h04);
    check_window(1'b1, MODE_OFFSET, 9'h07F, 8'h01);
    check_window(1'b0, MODE_PLAIN, 9'h07F, 8'h05);
    acc(1'b1, 9'h030, 8'h55, rd, e);
    cmp_err(e, 1'b1);
    acc(1'b1, REG_P1_HIGH, 8'hFF, rd, e);
    acc(1'b0, REG_P1_HIGH, 8'h00, rd, e);
    cmp_data(rd, 8'h01);
    set_ptr(1'b0, 9'h15C);
    @(posedge refClk);
    srst <= 1'b1;
    repeat (2) @(posedge refClk);
    srst <= 1'b0;
    get_ptr(1'b0, 9'h05C);
    conclude();
  end

  initial begin
    repeat (20000) @(posedge refClk);
    errorCnt++;
    $display("unexpected timeout at %0t: got %h expected %h", $time, 1'b0, 1'b1);
    conclude();
  end
endmodule : testbench
`default_nettype wire
